// File: pkg/eep_pkg.sv
// shared constants and types for the eeprom protect and control block
package eep_pkg;
  // array geometry
  localparam int ARRAY_BYTES = 512;
  localparam int BLOCK_BYTES = 128;
  // bus address map, byte addresses
  localparam logic [15:0] ARRAY_BASE = 16'h0800;
  localparam logic [15:0] ARRAY_LAST = 16'h09FF;
  localparam logic [15:0] SECURE_FIRST = 16'h08F0;
  localparam logic [15:0] SECURE_LAST = 16'h08FF;
  localparam logic [15:0] NV_CONFIG_ADDR = 16'hFE1C;
  localparam logic [15:0] CONTROL_ADDR = 16'hFE20;
  localparam logic [15:0] SHADOW_ADDR = 16'hFE24;
  // reset, erased and unmapped read values
  localparam logic [7:0] NV_ERASED = 8'hFF;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // program and erase mode encodings
  localparam logic [1:0] MODE_BYTE_PGM = 2'h0;
  localparam logic [1:0] MODE_BYTE_ERASE = 2'h1;
  localparam logic [1:0] MODE_BLOCK_ERASE = 2'h2;
  localparam logic [1:0] MODE_BULK_ERASE = 2'h3;
  // clock and recovery timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PDN_RECOVERY_NS = 1000;
  localparam int STOP_RECOVERY_NS = 1000;
  localparam int PDN_RECOVERY_CYC = (PDN_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_RECOVERY_CYC = (STOP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // array control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic clk_sel;
    logic ready;
    logic power_down;
    logic [1:0] mode;
    logic latch;
    logic rsvd;
    logic pump;
  } eep_ctrl_t;
  // configuration byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic redundant;
    logic [1:0] spare;
    logic security_n;
    logic [3:0] protect;
  } eep_cfg_t;
endpackage

// File: core/eep_mem.sv
// byte array storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module eep_mem #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic wr_and,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  // cell contents, shipped erased
  logic [7:0] mem_q [DEPTH] = '{default: eep_pkg::NV_ERASED};
  // program only pulls bits low, erase writes all ones
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_and ? (mem_q[wr_addr] & wr_data) : wr_data;
      end
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire

// File: core/eep_guard.sv
// decides whether high voltage may reach the latched target
`timescale 1ns/1ps
`default_nettype none
module eep_guard (
  input wire logic [8:0] addr,
  input wire logic to_nv,
  input wire logic [1:0] mode,
  input wire eep_pkg::eep_cfg_t cfg,
  output logic ok
);
  // array offset back to a full bus address
  wire [15:0] full_addr = eep_pkg::ARRAY_BASE | {7'h00, addr}; // RL3
  wire secure = ~cfg.security_n; // RL7
  wire in_secure = (full_addr >= eep_pkg::SECURE_FIRST) && (full_addr <= eep_pkg::SECURE_LAST); // RL7
  wire wide = (mode == eep_pkg::MODE_BLOCK_ERASE) || (mode == eep_pkg::MODE_BULK_ERASE);
  wire bulk = (mode == eep_pkg::MODE_BULK_ERASE);
  // block picked by the two top offset bits
  wire blk_prot = cfg.protect[addr[8:7]]; // RL1 RL24
  wire arr_ok = bulk ? ~(|cfg.protect) : ~blk_prot; // RL2 RL15
  // secure: no wide erase, no secured range, no config byte
  assign ok = to_nv ? (~secure & ~wide) : (arr_ok & ~(secure & (wide | in_secure))); // RL8 RL9 RL28
endmodule
`default_nettype wire

// File: core/eep_ctrl.sv
// eeprom protection, configuration shadow and program control with wishbone registers
// Function
// [RL1] four protectable 128-byte blocks, one bit each
// [RL2] protected block never gets high voltage
// [RL3] block 0 at 0800, array ends 09FF
// [RL4] protect changes act after reset or read
// [RL5] reset and config reads reload the shadow
// [RL6] config byte programmed like any array byte
// [RL7] security bit zero locks 08F0 to 08FF
// [RL8] secure: no wide erase, no config writes
// [RL9] secure: byte erase and reads still work
// [RL10] secure address writes are not latched
// [RL11] security once armed stays armed forever
// [RL12] pump clock select picks bus or oscillator
// [RL13] software uses oscillator below 8 MHz
// [RL14] power down disables array, needs recovery
// [RL15] mode bits pick program or erase kind
// [RL16] latch clear ignored while pump is on
// [RL17] pump needs latch and a valid write
// [RL18] clearing both only clears the pump
// [RL19] config byte at FE1C, erased all ones
// [RL20] software keeps redundant bit at zero
// [RL21] wait mode leaves the array alone
// [RL22] stop drops voltage, keeps pump, restores
// [RL23] stop exit needs recovery before access
// [RL24] protection judged from the latched address
// [RL25] latched writes capture, reads return capture
// [RL26] no pump without latch and valid write
// [RL27] mode bits frozen while pump is on
// [RL28] wide erases never touch the config byte
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl #(
  parameter int ARRAY_BYTES = 512,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic stop_mode,
  output logic hv_on_o,
  output logic pump_clk_sel_o,
  output logic array_ready_o,
  output eep_pkg::eep_cfg_t config_o
);
  // sequencer states for the array operation
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} eep_seq_t;

  // bus handshake state
  logic phase_q; // read data being fetched
  logic ack_q; // acknowledge pulse
  logic [7:0] dat_q; // registered read data
  // control and configuration
  eep_pkg::eep_ctrl_t ctrl_q; // array control register
  eep_pkg::eep_ctrl_t ctrl_d;
  eep_pkg::eep_cfg_t nv_q = eep_pkg::NV_ERASED; // nonvolatile config byte, no reset
  eep_pkg::eep_cfg_t shadow_q; // volatile copy used by the logic
  // latched target
  logic [AW-1:0] cap_addr_q; // latched array offset
  logic cap_nv_q; // latched target is the config byte
  logic [7:0] cap_data_q; // latched data
  logic cap_valid_q; // a valid write was latched
  // operation sequencer
  eep_seq_t seq_q;
  logic [AW-1:0] seq_addr_q; // byte under work
  logic [AW-1:0] seq_last_q; // final byte of the operation
  logic hv_q; // high voltage applied
  // recovery timing
  logic stop_q; // stop level one cycle ago
  logic [15:0] rec_q; // recovery countdown

  // request decode
  wire req = wb_cyc_i & wb_stb_i;
  wire fire = req & ack_q; // edge where the access completes
  wire wr_fire = fire & wb_we_i & wb_sel_i;
  wire rd_fire = fire & ~wb_we_i;
  wire hit_array = (wb_adr_i >= eep_pkg::ARRAY_BASE) && (wb_adr_i <= eep_pkg::ARRAY_LAST); // RL3
  wire hit_nv = (wb_adr_i == eep_pkg::NV_CONFIG_ADDR); // RL19
  wire hit_ctrl = (wb_adr_i == eep_pkg::CONTROL_ADDR);
  wire hit_shadow = (wb_adr_i == eep_pkg::SHADOW_ADDR);
  wire in_secure = (wb_adr_i >= eep_pkg::SECURE_FIRST) && (wb_adr_i <= eep_pkg::SECURE_LAST);
  wire secure = ~shadow_q.security_n; // RL11
  wire [AW-1:0] bus_off = wb_adr_i[AW-1:0];

  // a write that may be latched as the program target
  wire arr_ok_wr = hit_array & ~(secure & in_secure); // RL10
  wire nv_ok_wr = hit_nv & ~secure; // RL8 RL6
  wire valid_wr = wr_fire & ctrl_q.latch & ~ctrl_q.pump & (arr_ok_wr | nv_ok_wr); // RL25

  // control register write view
  wire ctrl_wr = wr_fire & hit_ctrl;
  wire eep_pkg::eep_ctrl_t wdat = eep_pkg::eep_ctrl_t'(wb_dat_i);
  wire pump_set_ok = ctrl_q.latch & cap_valid_q; // RL17 RL26
  wire recovering = (rec_q != 16'h0000);
  wire ready = ~recovering & ~stop_mode & ~stop_q & ~ctrl_q.power_down; // RL14 RL23

  // protection check on the latched target
  logic guard_ok;
  eep_guard u_guard (
    .addr(cap_addr_q),
    .to_nv(cap_nv_q),
    .mode(ctrl_q.mode),
    .cfg(shadow_q),
    .ok(guard_ok)
  );

  // voltage only while pumping, allowed, awake and powered
  wire hv_on = ctrl_q.pump & guard_ok & ~stop_mode & ~ctrl_q.power_down; // RL2 RL21 RL22
  wire seq_run = (seq_q == SEQ_RUN);
  wire is_pgm = (ctrl_q.mode == eep_pkg::MODE_BYTE_PGM);
  wire is_block = (ctrl_q.mode == eep_pkg::MODE_BLOCK_ERASE);
  wire is_bulk = (ctrl_q.mode == eep_pkg::MODE_BULK_ERASE);
  wire arr_write = seq_run & hv_on & ~cap_nv_q;
  wire nv_write = seq_run & hv_on & cap_nv_q; // RL28
  wire [7:0] op_data = is_pgm ? cap_data_q : eep_pkg::NV_ERASED; // RL15

  // first and last byte of the operation
  wire [AW-1:0] blk_first = {cap_addr_q[AW-1:AW-2], 7'h00};
  wire [AW-1:0] blk_last = {cap_addr_q[AW-1:AW-2], 7'h7F};
  wire [AW-1:0] op_first = is_bulk ? '0 : (is_block ? blk_first : cap_addr_q);
  wire [AW-1:0] op_last = is_bulk ? AW'(ARRAY_BYTES - 1) : (is_block ? blk_last : cap_addr_q);

  // array storage
  logic [7:0] mem_rd;
  eep_mem #(
    .DEPTH(ARRAY_BYTES),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .ce(ce),
    .wr_en(arr_write),
    .wr_and(is_pgm),
    .wr_addr(seq_addr_q),
    .wr_data(op_data),
    .rd_addr(bus_off),
    .rd_data(mem_rd)
  );

  // next control register value
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d.ready = 1'b0;
    ctrl_d.rsvd = 1'b0;
    if (ctrl_wr) begin
      ctrl_d.clk_sel = wdat.clk_sel; // RL12
      ctrl_d.power_down = wdat.power_down; // RL14
      // mode frozen while pumping
      if (!ctrl_q.pump) begin
        ctrl_d.mode = wdat.mode; // RL27
      end
      // latch cannot drop while pumping
      if (!ctrl_q.pump) begin
        ctrl_d.latch = wdat.latch; // RL16 RL18
      end
      // pump clears freely, sets only after a valid capture
      if (ctrl_q.pump) begin
        ctrl_d.pump = wdat.pump; // RL18
      end else begin
        ctrl_d.pump = wdat.pump & pump_set_ok; // RL17 RL26
      end
    end
  end

  // read data selection
  wire [7:0] arr_rd = ctrl_q.power_down ? eep_pkg::NV_ERASED : (ctrl_q.latch ? cap_data_q : mem_rd); // RL25
  wire [7:0] ctrl_rd = {ctrl_q.clk_sel, ready, ctrl_q[5:0]};
  wire [7:0] rd_mux = hit_array ? arr_rd :
                      hit_nv ? nv_q :
                      hit_ctrl ? ctrl_rd :
                      hit_shadow ? shadow_q :
                      eep_pkg::UNMAPPED_READ;

  // wishbone handshake, ack two cycles after the request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else if (ce) begin
      ack_q <= 1'b0;
      if (req && !phase_q && !ack_q) begin
        phase_q <= 1'b1; // array read address presented
      end else if (phase_q) begin
        phase_q <= 1'b0;
        ack_q <= req;
        dat_q <= rd_mux;
      end
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= eep_pkg::CONTROL_RESET; // RL12 RL14 RL15 RL16 RL17
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  // shadow reloads from the config byte on reset and on its reads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow_q <= nv_q; // RL5
    end else if (ce && rd_fire && hit_nv) begin
      shadow_q <= nv_q; // RL4 RL5
    end
  end

  // config byte keeps its value through reset
  always_ff @(posedge clk) begin
    if (ce && nv_write) begin
      nv_q <= is_pgm ? (nv_q & cap_data_q) : eep_pkg::NV_ERASED; // RL6
    end
  end

  // capture of the program target
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_addr_q <= '0;
      cap_nv_q <= 1'b0;
      cap_data_q <= 8'h00;
      cap_valid_q <= 1'b0;
    end else if (ce) begin
      if (valid_wr) begin
        cap_addr_q <= bus_off; // RL25
        cap_nv_q <= hit_nv;
        cap_data_q <= wb_dat_i;
        cap_valid_q <= 1'b1;
      end else if (!ctrl_q.latch) begin
        cap_valid_q <= 1'b0; // latch off forgets the target
      end
    end
  end

  // operation sequencer, pauses while voltage is off
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seq_q <= SEQ_IDLE;
      seq_addr_q <= '0;
      seq_last_q <= '0;
    end else if (ce) begin
      if (!ctrl_q.pump) begin
        seq_q <= SEQ_IDLE;
      end else begin
        case (seq_q)
          SEQ_IDLE: begin
            if (hv_on) begin
              seq_q <= SEQ_RUN;
              seq_addr_q <= op_first;
              seq_last_q <= op_last;
            end
          end
          SEQ_RUN: begin
            // resumes where it stopped after stop mode
            if (hv_on && seq_addr_q == seq_last_q) begin
              seq_q <= SEQ_DONE;
            end else if (hv_on) begin
              seq_addr_q <= seq_addr_q + 1'b1;
            end
          end
          default: begin
            seq_q <= SEQ_DONE; // hold until pump clears
          end
        endcase
      end
    end
  end

  // voltage register and recovery countdown
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hv_q <= 1'b0;
      stop_q <= 1'b0;
      rec_q <= 16'h0000;
    end else if (ce) begin
      hv_q <= hv_on; // RL22
      stop_q <= stop_mode;
      if (stop_q && !stop_mode) begin
        rec_q <= 16'(eep_pkg::STOP_RECOVERY_CYC); // RL23
      end else if (ctrl_wr && ctrl_q.power_down && !wdat.power_down) begin
        rec_q <= 16'(eep_pkg::PDN_RECOVERY_CYC); // RL14
      end else if (recovering) begin
        rec_q <= rec_q - 16'h0001;
      end
    end
  end

  // outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign hv_on_o = hv_q;
  assign pump_clk_sel_o = ctrl_q.clk_sel; // RL12
  assign array_ready_o = ready;
  assign config_o = shadow_q;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_hv_protect: assert property (hv_q && !cap_nv_q && !is_bulk |-> !shadow_q.protect[cap_addr_q[AW-1:AW-2]]) // RL2
    else $error("voltage applied to a protected block");
  a_hv_secure: assert property (hv_q && secure |-> !cap_nv_q && !is_block && !is_bulk) // RL8
    else $error("wide erase or config write while secure");
  a_hv_secrange: assert property (hv_q && secure |-> (cap_addr_q < 9'h0F0 || cap_addr_q > 9'h0FF)) // RL7
    else $error("voltage applied to secured range");
  a_pump_needs: assert property ($rose(ctrl_q.pump) |-> $past(ctrl_q.latch) && $past(cap_valid_q)) // RL17
    else $error("pump set without latch and valid write");
  a_latch_hold: assert property (ce && ctrl_wr && ctrl_q.pump && !wdat.latch |=> ctrl_q.latch) // RL18
    else $error("latch cleared while pump was set");
  a_mode_frozen: assert property (ce && ctrl_q.pump |=> ctrl_q.mode == $past(ctrl_q.mode)) // RL27
    else $error("mode changed while pumping");
  a_shadow_load: assert property (ce && rd_fire && hit_nv |=> shadow_q == $past(nv_q)) // RL4
    else $error("shadow not reloaded on config read");
  a_secure_nolatch: assert property (secure && in_secure && hit_array |-> !valid_wr) // RL10
    else $error("secured address latched");
  a_stop_hv: assert property (ce && stop_mode && ctrl_q.pump && !ctrl_wr |=> !hv_q && ctrl_q.pump) // RL22
    else $error("stop did not drop voltage or lost pump");
  a_nv_untouched: assert property (ce && (is_block || is_bulk) |=> nv_q == $past(nv_q)) // RL28
    else $error("wide erase changed config byte");
  a_ack_shape: assert property (req && !ack_q && !phase_q && ce ##1 ce |=> ack_q ##1 !ack_q)
    else $error("ack not two cycles then one pulse");
  // low power, clock enable and refusal checks
  a_pump_refuse: assert property (ce && ctrl_wr && !ctrl_q.pump && !pump_set_ok |=> !ctrl_q.pump) // RL26
    else $error("pump set without a valid capture");
  a_stop_ready: assert property ($fell(stop_mode) && $past(ce) |-> !ready) // RL23
    else $error("array ready right after stop release");
  a_ce_freeze: assert property (!ce |=> $stable(ctrl_q) && $stable(rec_q) && $stable(shadow_q)) // RL14
    else $error("state moved while clock enable low");

  c_byte_pgm: cover property (seq_run && hv_on && is_pgm && !cap_nv_q);
  c_block_erase: cover property (seq_run && hv_on && is_block ##1 seq_q == SEQ_DONE);
  c_shadow_read: cover property (rd_fire && hit_nv);
  c_ce_hold: cover property (!ce ##1 ce && recovering);
  c_stop_pause: cover property (seq_run && hv_q ##1 stop_mode ##[1:20] !stop_mode && hv_q);
endmodule
`default_nettype wire

// File: test/eep_cpu_model.sv
// cpu-side classic wishbone master model for the eeprom control block
`timescale 1ns/1ps
`default_nettype none
module eep_cpu_model (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [15:0] adr,
  output logic sel,
  output logic [7:0] dat_w,
  input wire logic [7:0] dat_r,
  input wire logic ack
);
  // bus idle from time zero, byte lane always selected
  initial begin
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 16'h0000;
    sel = 1'h1;
    dat_w = 8'h00;
  end
  // one cycle: hold until ack, take data there, release, idle a cycle
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'h1);
    q = dat_r;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    // released lines flip so a stale value never looks valid
    adr <= ~a;
    dat_w <= ~d;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/eep_ctrl_tb.sv
// self-checking bench for the eeprom protect and control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module eep_ctrl_tb;
  localparam logic [15:0] CA = eep_pkg::CONTROL_ADDR;
  localparam logic [15:0] NA = eep_pkg::NV_CONFIG_ADDR;
  // one row: mode, target, data, high voltage expected
  typedef struct {logic [1:0] m; logic [15:0] a; logic [7:0] d; logic hv;} eep_row_t;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic stop_mode = 1'h0;
  logic ce = 1'h1;
  logic cyc, stb, we, sel, ack, hv_on, clk_sel, ready;
  logic [15:0] adr;
  logic [7:0] dat_w, dat_r;
  eep_pkg::eep_cfg_t cfg;
  int num_errors = 0;
  int cmp_count = 0;
  // rows run with blocks 1 and 3 protected
  eep_row_t rows [6] = '{'{2'h0, 16'h087F, 8'hA5, 1'h1}, '{2'h0, 16'h0880, 8'hA5, 1'h0},
    '{2'h1, 16'h0900, 8'h00, 1'h1}, '{2'h0, 16'h09FF, 8'hA5, 1'h0},
    '{2'h3, 16'h0800, 8'h00, 1'h0}, '{2'h2, 16'h0980, 8'h00, 1'h0}};
  // bus clock, 100 ns
  always #50 clk = ~clk;
  eep_cpu_model i_cpu (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dat_w), .dat_r(dat_r), .ack(ack));
  eep_ctrl i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .stop_mode(stop_mode), .hv_on_o(hv_on), .pump_clk_sel_o(clk_sel),
    .array_ready_o(ready), .config_o(cfg));
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // wait n edges, then look at the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // reset held n edges
  task automatic rst(input int n);
    @(posedge clk);
    rst_b <= 1'h0;
    repeat (n) @(posedge clk);
    rst_b <= 1'h1;
    settle(0);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_cpu.xfer(1'h1, a, d, x);
  endtask
  // read and compare under a mask
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic [7:0] mk);
    logic [7:0] x;
    i_cpu.xfer(1'h0, a, 8'h00, x);
    `CHK("read data", e, x & mk)
  endtask
  // latch, target write, pump on, optional stop, pump off, latch off
  task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d,
      input logic hv, input int wt, input bit stp);
    wr(CA, {3'h0, m, 3'h4});
    wr(a, d);
    if (hv && !a[15]) rdc(a, d, 8'hFF);
    wr(CA, {3'h0, m, 3'h5});
    settle(0);
    `CHK("hv_on", hv, hv_on)
    if (stp) begin
      @(posedge clk) stop_mode <= 1'h1;
      settle(2);
      `CHK("hv_on", 1'h0, hv_on)
      @(posedge clk) stop_mode <= 1'h0;
      settle(2);
      `CHK("hv_on", 1'h1, hv_on)
      `CHK("ready", 1'h0, ready)
      settle(10);
      `CHK("ready", 1'h1, ready)
    end
    if (hv) begin
      wr(CA, {3'h0, m, 3'h1});
      rdc(CA, {3'h0, m, 3'h5}, 8'hBF);
    end
    settle(wt);
    wr(CA, 8'h00);
    if (hv) begin
      settle(0);
      `CHK("hv_on", 1'h0, hv_on)
      rdc(CA, {3'h0, m, 3'h4}, 8'hBF);
    end
    wr(CA, 8'h00);
  endtask
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    rst(20);
    `CHK("hv_on", 1'h0, hv_on)
    `CHK("clk_sel", 1'h0, clk_sel)
    `CHK("config", 8'hFF, cfg)
    rdc(CA, 8'h00, 8'hBF);
    rdc(eep_pkg::SHADOW_ADDR, 8'hFF, 8'hFF);
    rdc(16'h1234, eep_pkg::UNMAPPED_READ, 8'hFF);
    wr(CA, 8'h01);
    settle(0);
    `CHK("hv_on", 1'h0, hv_on)
    op(2'h0, 16'h0800, 8'h5A, 1'h0, 0, 1'h0);
    rdc(16'h0800, 8'hFF, 8'hFF);
    op(2'h0, NA, 8'h7A, 1'h1, 5, 1'h0);
    `CHK("config", 8'hFF, cfg)
    rdc(NA, 8'h7A, 8'hFF);
    settle(0);
    `CHK("config", 8'h7A, cfg)
    for (int i = 0; i < 6; i++) begin
      op(rows[i].m, rows[i].a, rows[i].d, rows[i].hv, 5, 1'h0);
    end
    rdc(16'h087F, 8'hA5, 8'hFF);
    op(2'h0, NA, 8'h70, 1'h1, 5, 1'h0);
    rdc(NA, 8'h70, 8'hFF);
    op(2'h3, 16'h0900, 8'h00, 1'h1, 600, 1'h0);
    rdc(16'h087F, 8'hFF, 8'hFF);
    rdc(NA, 8'h70, 8'hFF);
    op(2'h0, 16'h08A0, 8'h3C, 1'h1, 5, 1'h0);
    rdc(16'h08A0, 8'h3C, 8'hFF);
    op(2'h2, 16'h0880, 8'h00, 1'h1, 140, 1'h1);
    rdc(16'h08A0, 8'hFF, 8'hFF);
    wr(CA, 8'h80);
    settle(0);
    `CHK("clk_sel", 1'h1, clk_sel)
    wr(CA, 8'h20);
    settle(0);
    `CHK("ready", 1'h0, ready)
    rdc(16'h0800, 8'hFF, 8'hFF);
    wr(CA, 8'h00);
    settle(2);
    `CHK("ready", 1'h0, ready)
    @(posedge clk) ce <= 1'h0;
    settle(20);
    `CHK("ready", 1'h0, ready)
    @(posedge clk) ce <= 1'h1;
    settle(10);
    `CHK("ready", 1'h1, ready)
    op(2'h0, NA, 8'h60, 1'h1, 5, 1'h0);
    rdc(NA, 8'h60, 8'hFF);
    op(2'h0, 16'h0800, 8'h11, 1'h1, 5, 1'h0);
    op(2'h1, 16'h0800, 8'h00, 1'h1, 5, 1'h0);
    rdc(16'h0800, 8'hFF, 8'hFF);
    op(2'h2, 16'h0800, 8'h00, 1'h0, 0, 1'h0);
    op(2'h3, 16'h0800, 8'h00, 1'h0, 0, 1'h0);
    rdc(16'h08F0, 8'hFF, 8'hFF);
    wr(CA, 8'h80);
    rst(2);
    `CHK("config", 8'h60, cfg)
    `CHK("clk_sel", 1'h0, clk_sel)
    op(2'h0, 16'h08F0, 8'h00, 1'h0, 0, 1'h0);
    rst(2);
    op(2'h0, NA, 8'h00, 1'h0, 0, 1'h0);
    rdc(NA, 8'h60, 8'hFF);
    end_sim();
  end
endmodule
`default_nettype wire
